// ---- common/dwf_pkg.sv ----
// Shared constants for the task-file command path and its host controller
package dwf_pkg;
   // Task-file register addresses
   localparam logic [2:0] TF_DATA    = 3'h0;
   localparam logic [2:0] TF_FEAT    = 3'h1;
   localparam logic [2:0] TF_SCNT    = 3'h2;
   localparam logic [2:0] TF_SNUM    = 3'h3;
   localparam logic [2:0] TF_CYL_LO  = 3'h4;
   localparam logic [2:0] TF_CYL_HI  = 3'h5;
   localparam logic [2:0] TF_DRVHD   = 3'h6;
   localparam logic [2:0] TF_CMD     = 3'h7;
   // Command codes
   localparam logic [7:0] CMD_WR_VERIFY = 8'h3c;
   localparam logic [7:0] CMD_FMT_TRACK = 8'h50;
   localparam logic [3:0] CMD_SEEK_HI   = 4'h7;
   // Status, error and drive/head bit positions
   localparam int ST_BSY   = 7;
   localparam int ST_DRDY  = 6;
   localparam int ST_DSC   = 4;
   localparam int ST_DRQ   = 3;
   localparam int ST_ERR   = 0;
   localparam int ER_IDNF  = 4;
   localparam int ER_ABRT  = 2;
   localparam int DH_LBA   = 6;
   localparam int HEAD_W   = 4;
   // Sector geometry and completion values
   localparam int         SECTOR_BYTES = 512;
   localparam int         SECTOR_WORDS = SECTOR_BYTES / 2;
   localparam logic [7:0] FMT_TYPE_STD = 8'h00;
   localparam logic [7:0] SN_AFTER_FMT = 8'h01;
   localparam logic [7:0] CNT_DONE     = 8'h00;
   // Host controller register offsets
   localparam logic [4:0] OFS_TF_LO    = 5'h00;
   localparam logic [4:0] OFS_TF_HI    = 5'h04;
   localparam logic [4:0] OFS_CMD      = 5'h08;
   localparam logic [4:0] OFS_DATA     = 5'h0c;
   localparam logic [4:0] OFS_STATUS   = 5'h10;
   localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h18;
   // Interrupt status bits
   localparam int IRQ_DEV = 0;
   localparam int IRQ_ERR = 1;
   localparam int IRQ_W   = 2;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- common/dwf_tf_if.sv ----
// Synchronous task-file port between host controller and drive
`timescale 1ns/10ps
interface dwf_tf_if;
   logic [2:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        wr;
   logic        rd;
   logic        intrq;
   modport dev
   (
      input  addr,
      input  wdata,
      input  wr,
      input  rd,
      output rdata,
      output intrq
   );
   modport host
   (
      output addr,
      output wdata,
      output wr,
      output rd,
      input  rdata,
      input  intrq
   );
endinterface

// ---- verilog/dwf_drive.sv ----
// Drive end: write verify, format track and seek command execution
`timescale 1ns/10ps
module dwf_drive #(
   parameter int SPT   = 63,
   parameter int HEADS = 16,
   parameter int CYLS  = 16383
)
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   dwf_tf_if.dev            tf,
   output logic             seek_req,
   output logic [15:0]      seek_cyl,
   output logic [3:0]       seek_head,
   input  wire logic        seek_done,
   output logic             media_valid,
   input  wire logic        media_ready,
   output logic             media_fmt,
   output logic [15:0]      media_cyl,
   output logic [3:0]       media_head,
   output logic [7:0]       media_sect,
   output logic [15:0]      media_data
);
   localparam int         WRD  = dwf_pkg::SECTOR_WORDS;
   localparam logic [8:0] LAST = 9'(WRD - 1);
   localparam logic [8:0] FULL = 9'(WRD);
   localparam logic [27:0] TOTAL = 28'(CYLS * HEADS * SPT);

   typedef enum logic [2:0] {S_IDLE, S_XFER, S_SEEK, S_WRITE, S_FMT} dwf_state_t;

   dwf_state_t  state_r;
   logic [7:0]  feat_r;
   logic [7:0]  cnt_r;
   logic [7:0]  sect_r;
   logic [7:0]  dh_r;
   logic [7:0]  cmd_r;
   logic [7:0]  errreg_r;
   logic [15:0] cyl_r;
   logic [15:0] cur_cyl_r;
   logic        bsy_r;
   logic        drq_r;
   logic        dsc_r;
   logic        err_r;
   logic        intrq_r;
   logic [8:0]  widx_r;
   logic [8:0]  remain_r;
   logic [15:0] buf_r [WRD];
   logic        lba_mode;
   logic [27:0] lba_w;
   logic [27:0] lba_inc;
   logic [15:0] tgt_cyl;
   logic [3:0]  tgt_head;
   logic [7:0]  tgt_sect;
   logic        addr_bad;
   logic        is_seek;
   logic        need_seek;
   logic        reg_wr;
   logic        data_wr;
   logic        stat_rd;
   logic        media_hs;
   logic [7:0]  adv_sect;
   logic [3:0]  adv_head;
   logic [15:0] adv_cyl;
   logic [7:0]  status;

   assign lba_mode = dh_r[dwf_pkg::DH_LBA];
   assign lba_w    = {dh_r[3:0], cyl_r, sect_r};
   assign lba_inc  = lba_w + 28'h1;
   // Target address from CHS or LBA registers
   assign tgt_cyl  = lba_mode ? 16'(lba_w / 28'(HEADS * SPT)) : cyl_r;
   assign tgt_head = lba_mode ? 4'((lba_w / 28'(SPT)) % 28'(HEADS)) : dh_r[3:0];
   assign tgt_sect = lba_mode ? 8'((lba_w % 28'(SPT)) + 28'h1) : sect_r;
   assign addr_bad = lba_mode ? (lba_w >= TOTAL)
                   : (sect_r == 8'h0 || 32'(sect_r) > SPT
                      || 32'(dh_r[3:0]) >= HEADS || 32'(cyl_r) >= CYLS);
   assign is_seek   = cmd_r[7:4] == dwf_pkg::CMD_SEEK_HI;
   assign need_seek = is_seek || tgt_cyl != cur_cyl_r;
   assign reg_wr    = tf.wr && state_r == S_IDLE && tf.addr != dwf_pkg::TF_DATA;
   assign data_wr   = tf.wr && tf.addr == dwf_pkg::TF_DATA && drq_r;
   assign stat_rd   = tf.rd && tf.addr == dwf_pkg::TF_CMD;
   assign media_hs  = media_valid && media_ready;

   assign status = {bsy_r, 1'b1, 1'b0, dsc_r, drq_r, 2'b00, err_r};
   assign tf.intrq = intrq_r;

   always_comb
   begin
      unique case (tf.addr)
         dwf_pkg::TF_FEAT:   tf.rdata = {8'h00, errreg_r};
         dwf_pkg::TF_SCNT:   tf.rdata = {8'h00, cnt_r};
         dwf_pkg::TF_SNUM:   tf.rdata = {8'h00, sect_r};
         dwf_pkg::TF_CYL_LO: tf.rdata = {8'h00, cyl_r[7:0]};
         dwf_pkg::TF_CYL_HI: tf.rdata = {8'h00, cyl_r[15:8]};
         dwf_pkg::TF_DRVHD:  tf.rdata = {8'h00, dh_r};
         dwf_pkg::TF_CMD:    tf.rdata = {8'h00, status};
         default:            tf.rdata = 16'h0000;
      endcase
   end

   // Next sector address, interleave one
   always_comb
   begin
      adv_sect = sect_r + 8'h1;
      adv_head = dh_r[3:0];
      adv_cyl  = cyl_r;
      if (lba_mode)
      begin
         adv_sect = lba_inc[7:0];
         adv_cyl  = lba_inc[23:8];
         adv_head = lba_inc[27:24];
      end
      else if (32'(sect_r) >= SPT)
      begin
         adv_sect = 8'h1;
         if (32'(dh_r[3:0]) >= HEADS - 1)
         begin
            adv_head = 4'h0;
            adv_cyl  = cyl_r + 16'h1;
         end
         else
            adv_head = dh_r[3:0] + 4'h1;
      end
   end

   // Sector buffer; words beyond one sector never stored
   always_ff @(posedge clk)
   begin
      if (ce && data_wr && state_r == S_XFER)
         buf_r[widx_r[7:0]] <= tf.wdata;
   end

   assign media_data = media_fmt ? {widx_r[7:0], dwf_pkg::FMT_TYPE_STD}
                                 : buf_r[widx_r[7:0]];
   assign media_cyl  = tgt_cyl;
   assign media_head = tgt_head;
   assign media_sect = tgt_sect;
   assign seek_cyl   = tgt_cyl;
   assign seek_head  = tgt_head;

   // Command sequencing, status and task file
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_r     <= S_IDLE;
         feat_r      <= 8'h00;
         cnt_r       <= 8'h00;
         sect_r      <= 8'h00;
         dh_r        <= 8'h00;
         cmd_r       <= 8'h00;
         errreg_r    <= 8'h00;
         cyl_r       <= 16'h0000;
         cur_cyl_r   <= 16'h0000;
         {bsy_r, drq_r, dsc_r, err_r, intrq_r} <= 5'b00000;
         widx_r      <= 9'h000;
         remain_r    <= 9'h000;
         seek_req    <= 1'b0;
         media_valid <= 1'b0;
         media_fmt   <= 1'b0;
      end
      else if (ce)
      begin
         if (stat_rd)
            intrq_r <= 1'b0;
         unique case (state_r)
            S_IDLE:
               if (reg_wr)
               begin
                  unique case (tf.addr)
                     dwf_pkg::TF_FEAT:   feat_r        <= tf.wdata[7:0];
                     dwf_pkg::TF_SCNT:   cnt_r         <= tf.wdata[7:0];
                     dwf_pkg::TF_SNUM:   sect_r        <= tf.wdata[7:0];
                     dwf_pkg::TF_CYL_LO: cyl_r[7:0]    <= tf.wdata[7:0];
                     dwf_pkg::TF_CYL_HI: cyl_r[15:8]   <= tf.wdata[7:0];
                     dwf_pkg::TF_DRVHD:  dh_r          <= tf.wdata[7:0];
                     default:
                     begin
                        cmd_r    <= tf.wdata[7:0];
                        err_r    <= 1'b0;
                        errreg_r <= 8'h00;
                        widx_r   <= 9'h000;
                        remain_r <= cnt_r == 8'h00 ? FULL : {1'b0, cnt_r};
                        if (tf.wdata[7:0] == dwf_pkg::CMD_WR_VERIFY && !addr_bad)
                        begin
                           drq_r   <= 1'b1;
                           state_r <= S_XFER;
                        end
                        else if (tf.wdata[7:0] == dwf_pkg::CMD_FMT_TRACK && !lba_mode)
                        begin
                           drq_r   <= 1'b1;
                           state_r <= S_XFER;
                        end
                        else if (tf.wdata[7:4] == dwf_pkg::CMD_SEEK_HI && !addr_bad)
                        begin
                           bsy_r   <= 1'b1;
                           dsc_r   <= 1'b0;
                           state_r <= S_SEEK;
                        end
                        else
                        begin
                           err_r   <= 1'b1;
                           intrq_r <= 1'b1;
                           if (tf.wdata[7:0] == dwf_pkg::CMD_WR_VERIFY
                               || tf.wdata[7:4] == dwf_pkg::CMD_SEEK_HI)
                              errreg_r[dwf_pkg::ER_IDNF] <= 1'b1;
                           else
                              errreg_r[dwf_pkg::ER_ABRT] <= 1'b1;
                        end
                     end
                  endcase
               end
            S_XFER:
               if (data_wr)
               begin
                  widx_r <= widx_r + 9'h1;
                  if (widx_r == LAST)
                  begin
                     drq_r   <= 1'b0;
                     bsy_r   <= 1'b1;
                     state_r <= S_SEEK;
                  end
               end
            S_SEEK:
            begin
               widx_r <= cmd_r == dwf_pkg::CMD_FMT_TRACK ? 9'h1 : 9'h0;
               if (need_seek && !seek_done)
                  seek_req <= 1'b1;
               else
               begin
                  seek_req  <= 1'b0;
                  cur_cyl_r <= tgt_cyl;
                  if (is_seek)
                  begin
                     dsc_r   <= 1'b1;
                     bsy_r   <= 1'b0;
                     intrq_r <= 1'b1;
                     state_r <= S_IDLE;
                  end
                  else
                  begin
                     media_valid <= 1'b1;
                     media_fmt   <= cmd_r == dwf_pkg::CMD_FMT_TRACK;
                     state_r     <= cmd_r == dwf_pkg::CMD_FMT_TRACK ? S_FMT : S_WRITE;
                  end
               end
            end
            S_WRITE:
               if (media_hs)
               begin
                  widx_r <= widx_r + 9'h1;
                  if (widx_r == LAST)
                  begin
                     media_valid <= 1'b0;
                     widx_r      <= 9'h000;
                     remain_r    <= remain_r - 9'h1;
                     intrq_r     <= 1'b1;
                     bsy_r       <= 1'b0;
                     if (remain_r == 9'h1)
                     begin
                        cnt_r   <= dwf_pkg::CNT_DONE;
                        state_r <= S_IDLE;
                     end
                     else
                     begin
                        cnt_r       <= cnt_r - 8'h1;
                        sect_r      <= adv_sect;
                        cyl_r       <= adv_cyl;
                        dh_r[3:0]   <= adv_head;
                        drq_r       <= 1'b1;
                        state_r     <= S_XFER;
                     end
                  end
               end
            S_FMT:
               if (media_hs)
               begin
                  widx_r <= widx_r + 9'h1;
                  if (32'(widx_r) >= SPT)
                  begin
                     media_valid <= 1'b0;
                     media_fmt   <= 1'b0;
                     sect_r      <= dwf_pkg::SN_AFTER_FMT;
                     cnt_r       <= dwf_pkg::CNT_DONE;
                     bsy_r       <= 1'b0;
                     intrq_r     <= 1'b1;
                     state_r     <= S_IDLE;
                  end
               end
         endcase
      end
   end
endmodule

// ---- verilog/dwf_host.sv ----
// Host end: AXI4-Lite register front and task-file sequencer
`timescale 1ns/10ps
module dwf_host
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic [4:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [4:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output logic             irq,
   dwf_tf_if.host           tf
);
   typedef enum logic [1:0] {RD_IDLE, RD_STAT, RD_ERR} dwf_rd_t;

   dwf_rd_t     rd_r;
   logic [2:0]  seq_r;
   logic [31:0] tf_lo_r;
   logic [31:0] tf_hi_r;
   logic [7:0]  cmd_code_r;
   logic [7:0]  dev_stat_r;
   logic [7:0]  dev_err_r;
   logic [1:0]  irq_stat_r;
   logic [1:0]  irq_mask_r;
   logic [1:0]  irq_set;
   logic [7:0]  seq_val;
   logic        wr_fire;
   logic        ar_fire;
   logic        fetch_r;

   // All register writes wait while a sequence or status read runs or is pending
   assign awready = awvalid && wvalid && !bvalid && seq_r == 3'h0
                    && rd_r == RD_IDLE && !tf.intrq && !fetch_r;
   assign wready  = awready;
   assign wr_fire = awready;
   assign arready = !rvalid;
   assign ar_fire = arvalid && arready;
   assign irq     = |(irq_stat_r & irq_mask_r);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            res[i*8 +: 8] = nw[i*8 +: 8];
      return res;
   endfunction

   always_comb
   begin
      unique case (seq_r)
         dwf_pkg::TF_FEAT:   seq_val = tf_lo_r[7:0];
         dwf_pkg::TF_SCNT:   seq_val = tf_lo_r[15:8];
         dwf_pkg::TF_SNUM:   seq_val = tf_lo_r[23:16];
         dwf_pkg::TF_CYL_LO: seq_val = tf_hi_r[7:0];
         dwf_pkg::TF_CYL_HI: seq_val = tf_hi_r[15:8];
         dwf_pkg::TF_DRVHD:  seq_val = tf_hi_r[23:16];
         default:            seq_val = cmd_code_r;
      endcase
   end

   // Software registers and write response
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tf_lo_r    <= 32'h0000_0000;
         tf_hi_r    <= 32'h0000_0000;
         cmd_code_r <= 8'h00;
         irq_mask_r <= 2'h0;
         bvalid     <= 1'b0;
         bresp      <= dwf_pkg::RESP_OKAY;
      end
      else if (ce)
      begin
         if (bvalid && bready)
            bvalid <= 1'b0;
         if (wr_fire)
         begin
            bvalid <= 1'b1;
            bresp  <= dwf_pkg::RESP_OKAY;
            unique case (awaddr)
               dwf_pkg::OFS_TF_LO:    tf_lo_r <= merge(tf_lo_r, wdata, wstrb);
               dwf_pkg::OFS_TF_HI:    tf_hi_r <= merge(tf_hi_r, wdata, wstrb);
               dwf_pkg::OFS_CMD:      cmd_code_r <= wdata[7:0];
               dwf_pkg::OFS_DATA:     ;
               dwf_pkg::OFS_IRQ_MASK: irq_mask_r <= wdata[1:0];
               default:               bresp <= dwf_pkg::RESP_SLVERR;
            endcase
         end
      end
   end

   // Task-file port: register sequence, data words, status fetch
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         seq_r      <= 3'h0;
         rd_r       <= RD_IDLE;
         tf.wr      <= 1'b0;
         tf.rd      <= 1'b0;
         tf.addr    <= dwf_pkg::TF_DATA;
         tf.wdata   <= 16'h0000;
         dev_stat_r <= 8'h00;
         dev_err_r  <= 8'h00;
         fetch_r    <= 1'b0;
      end
      else if (ce)
      begin
         tf.wr <= 1'b0;
         tf.rd <= 1'b0;
         fetch_r <= tf.wr && tf.addr == dwf_pkg::TF_CMD;
         if (rd_r == RD_STAT)
         begin
            dev_stat_r <= tf.rdata[7:0];
            tf.rd      <= 1'b1;
            tf.addr    <= dwf_pkg::TF_FEAT;
            rd_r       <= RD_ERR;
         end
         else if (rd_r == RD_ERR)
         begin
            dev_err_r <= tf.rdata[7:0];
            rd_r      <= RD_IDLE;
         end
         else if (seq_r != 3'h0)
         begin
            tf.wr    <= 1'b1;
            tf.addr  <= seq_r;
            tf.wdata <= {8'h00, seq_val};
            seq_r    <= seq_r == dwf_pkg::TF_CMD ? 3'h0 : seq_r + 3'h1;
         end
         else if (tf.intrq || fetch_r)
         begin
            tf.rd   <= 1'b1;
            tf.addr <= dwf_pkg::TF_CMD;
            rd_r    <= RD_STAT;
         end
         else if (wr_fire && awaddr == dwf_pkg::OFS_CMD)
            seq_r <= dwf_pkg::TF_FEAT;
         else if (wr_fire && awaddr == dwf_pkg::OFS_DATA)
         begin
            tf.wr    <= 1'b1;
            tf.addr  <= dwf_pkg::TF_DATA;
            tf.wdata <= wdata[15:0];
         end
      end
   end

   assign irq_set[dwf_pkg::IRQ_DEV] = rd_r == RD_STAT && tf.intrq;
   assign irq_set[dwf_pkg::IRQ_ERR] = rd_r == RD_STAT && tf.rdata[dwf_pkg::ST_ERR];

   // Sticky events, cleared by reading them; a new event wins
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         irq_stat_r <= 2'h0;
      else if (ce)
         irq_stat_r <= ((ar_fire && araddr == dwf_pkg::OFS_IRQ_STAT) ? 2'h0 : irq_stat_r)
                       | irq_set;
   end

   // Read channel
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= dwf_pkg::RESP_OKAY;
      end
      else if (ce)
      begin
         if (rvalid && rready)
            rvalid <= 1'b0;
         if (ar_fire)
         begin
            rvalid <= 1'b1;
            rresp  <= dwf_pkg::RESP_OKAY;
            unique case (araddr)
               dwf_pkg::OFS_TF_LO:    rdata <= tf_lo_r;
               dwf_pkg::OFS_TF_HI:    rdata <= tf_hi_r;
               dwf_pkg::OFS_CMD:      rdata <= {24'h000000, cmd_code_r};
               dwf_pkg::OFS_STATUS:
                  rdata <= {15'h0000, seq_r != 3'h0 || rd_r != RD_IDLE, dev_err_r, dev_stat_r};
               dwf_pkg::OFS_IRQ_STAT: rdata <= {30'h0, irq_stat_r};
               dwf_pkg::OFS_IRQ_MASK: rdata <= {30'h0, irq_mask_r};
               default:
               begin
                  rdata <= 32'h0000_0000;
                  rresp <= dwf_pkg::RESP_SLVERR;
               end
            endcase
         end
      end
   end
endmodule

// ---- test/dwf_chk.sv ----
// Checker on the task-file signals between host and drive
`timescale 1ns/10ps
module dwf_chk
(
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [2:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic        intrq
);
   logic lba_r;
   logic seek_r;
   wire  st  = addr == dwf_pkg::TF_CMD;
   wire  cmd = wr && st;
   wire  fmt = cmd && wdata[7:0] == dwf_pkg::CMD_FMT_TRACK;
   wire  skc = cmd && wdata[7:4] == dwf_pkg::CMD_SEEK_HI;
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
         lba_r <= 1'b0;
      else if (wr && addr == dwf_pkg::TF_DRVHD)
         lba_r <= wdata[dwf_pkg::DH_LBA];
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
         seek_r <= 1'b0;
      else if (skc || (rd && st && intrq))
         seek_r <= skc;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   seek_busy_a: assert property (skc ##1 st |-> rdata[7] != rdata[0])
      else $error("Seek command left busy low");
   fmt_drq_a: assert property (fmt && !lba_r ##1 st |-> rdata[3] && !rdata[7])
      else $error("Format did not raise data request");
   lba_abort_a: assert property (fmt && lba_r ##1 st |-> !rdata[dwf_pkg::ST_DRQ])
      else $error("Format in block addressing raised data request");
   wv_drq_a: assert property (cmd && wdata[7:0] == 8'h3c ##1 st |-> rdata[3])
      else $error("Write verify did not raise data request");
   drq_bsy_a: assert property (st |-> !(rdata[7] && rdata[3]))
      else $error("Busy and data request high together");
   irq_fetch_a: assert property ($rose(intrq) |-> ##[1:20] (rd && st && !rdata[7]))
      else $error("Interrupt not followed by idle status");
   irq_clear_a: assert property (rd && st && intrq |=> !intrq)
      else $error("Status read did not clear interrupt");
   seek_end_a: assert property (rd && st && intrq && seek_r && !rdata[0] |-> rdata[4])
      else $error("Seek ended without seek complete");
   cover property (fmt && !lba_r);
   cover property (skc);
   cover property (cmd && wdata[7:0] == 8'h3c);
endmodule

// ---- test/tb_disk_write_format_seek_cmds.sv ----
// Bench joining host and drive, driven over the register bus
`timescale 1ns/10ps
module tb_disk_write_format_seek_cmds;
   logic        clk = 1'b0, nrst = 1'b0, seek_done = 1'b0, media_ready = 1'b0;
   logic [4:0]  awaddr = 5'h0, araddr = 5'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic        awready, wready, arready, bvalid, rvalid, irq, seek_req, media_valid, media_fmt;
   logic [1:0]  bresp, rresp;
   logic [15:0] seek_cyl, media_cyl, media_data;
   logic [3:0]  seek_head, media_head;
   logic [7:0]  media_sect;
   int          err_count = 0, checks = 0, cyc = 0, nf = 0, nw = 0, ns = 0;
   dwf_tf_if tf();
   dwf_host dwf_host_i (.clk, .nrst, .ce(1'b1), .awaddr, .awvalid, .awready, .wdata,
      .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .irq, .tf(tf));
   dwf_drive #(.SPT(4)) dwf_drive_i (.clk, .nrst, .ce(1'b1), .tf(tf), .seek_req, .seek_cyl,
      .seek_head, .seek_done, .media_valid, .media_ready, .media_fmt, .media_cyl, .media_head,
      .media_sect, .media_data);
   dwf_chk dwf_chk_i (.clk, .nrst, .addr(tf.addr), .wdata(tf.wdata), .rdata(tf.rdata),
      .wr(tf.wr), .rd(tf.rd), .intrq(tf.intrq));
   always #25 clk = ~clk;
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task give_verdict();
      if (err_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge clk); while (!awready);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge clk); while (!bvalid);
      bready <= 1'b0;
      check("bresp", bresp, r);
      @(posedge clk);
   endtask
   task automatic axr(input logic [4:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      rready <= 1'b0;
      rv = rdata;
      check("rresp", rresp, dwf_pkg::RESP_OKAY);
      @(posedge clk);
   endtask
   task automatic wirq();
      while (!irq) @(posedge clk);
      axr(dwf_pkg::OFS_IRQ_STAT);
      axr(dwf_pkg::OFS_STATUS);
   endtask
   task automatic sect(input int b, input logic f);
      logic [31:0] d;
      do axr(dwf_pkg::OFS_STATUS); while (rv[3] !== 1'b1);
      check("busy", rv[7], 1'b0);
      for (int k = 0; k < 256; k++)
      begin
         d = k < 4 ? {16'h0, 8'(4 - k), 8'(k * 16 + 1)} : 32'hbeef;
         axw(dwf_pkg::OFS_DATA, f ? d : 32'(b + k), dwf_pkg::RESP_OKAY);
      end
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      seek_done <= seek_req && !seek_done;
      media_ready <= !media_ready;
      if (seek_done)
         ns <= ns + 1;
      if (media_valid && media_ready && media_fmt)
      begin
         check("fsect", {media_cyl[11:0], media_head, media_data},
            {12'h3, 4'h0, 8'(nf + 1), 8'h00});
         nf <= nf + 1;
      end
      if (media_valid && media_ready && !media_fmt)
      begin
         check("wdat", {media_cyl, media_data}, {16'h5, 16'(nw)});
         check("wsect", media_sect, 8'(1 + nw / 256));
         nw <= nw + 1;
      end
      if (cyc == 40000)
      begin
         err_count++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      axw(5'h1c, 32'h0, dwf_pkg::RESP_SLVERR);
      axw(dwf_pkg::OFS_IRQ_MASK, 32'h3, dwf_pkg::RESP_OKAY);
      axw(dwf_pkg::OFS_TF_LO, 32'h00010100, dwf_pkg::RESP_OKAY);
      for (int c = 0; c < 16; c++)
      begin
         axw(dwf_pkg::OFS_TF_HI, 32'(c + 1), dwf_pkg::RESP_OKAY);
         axw(dwf_pkg::OFS_CMD, 32'(8'h70 + c), dwf_pkg::RESP_OKAY);
         wirq();
         check("seek", {rv[16:0], 5'(ns), seek_head, 6'(seek_cyl)},
            {17'h50, 5'(c + 1), 4'h0, 6'(c + 1)});
      end
      axw(dwf_pkg::OFS_TF_LO, 32'h00000100, dwf_pkg::RESP_OKAY);
      axw(dwf_pkg::OFS_CMD, 32'h70, dwf_pkg::RESP_OKAY);
      wirq();
      check("idnf", {rv[12], rv[7], rv[0], 5'(ns)}, {3'b101, 5'h10});
      axw(dwf_pkg::OFS_IRQ_MASK, 32'h0, dwf_pkg::RESP_OKAY);
      axw(dwf_pkg::OFS_TF_HI, 32'h00400003, dwf_pkg::RESP_OKAY);
      axw(dwf_pkg::OFS_CMD, 32'h50, dwf_pkg::RESP_OKAY);
      do
      begin
         axr(dwf_pkg::OFS_IRQ_STAT);
         check("masked", irq, 1'b0);
      end
      while (rv[0] !== 1'b1);
      axr(dwf_pkg::OFS_STATUS);
      check("abrt", {rv[10], rv[3], rv[0]}, 3'b101);
      axw(dwf_pkg::OFS_IRQ_MASK, 32'h3, dwf_pkg::RESP_OKAY);
      axw(dwf_pkg::OFS_TF_LO, 32'h00010100, dwf_pkg::RESP_OKAY);
      axw(dwf_pkg::OFS_TF_HI, 32'h00000003, dwf_pkg::RESP_OKAY);
      axw(dwf_pkg::OFS_CMD, 32'h50, dwf_pkg::RESP_OKAY);
      sect(0, 1'b1);
      wirq();
      check("fmt", {rv[7], rv[3], rv[0], 8'(nf)}, {3'b000, 8'h4});
      axw(dwf_pkg::OFS_TF_LO, 32'h00010200, dwf_pkg::RESP_OKAY);
      axw(dwf_pkg::OFS_TF_HI, 32'h00000005, dwf_pkg::RESP_OKAY);
      axw(dwf_pkg::OFS_CMD, 32'h3c, dwf_pkg::RESP_OKAY);
      sect(0, 1'b0);
      wirq();
      sect(256, 1'b0);
      wirq();
      check("wv", {rv[7], rv[3], rv[0], 10'(nw), 5'(ns)}, {3'b000, 10'd512, 5'd18});
      axw(dwf_pkg::OFS_TF_LO, 32'h00090100, dwf_pkg::RESP_OKAY);
      axw(dwf_pkg::OFS_TF_HI, 32'h00400000, dwf_pkg::RESP_OKAY);
      axw(dwf_pkg::OFS_CMD, 32'h70, dwf_pkg::RESP_OKAY);
      wirq();
      check("lba", {rv[7:0], seek_head, 4'(seek_cyl)}, {8'h50, 4'h2, 4'h0});
      give_verdict();
   end
endmodule
